// >>> design/pbsi_map.vh
// Constants shared by the pipelined burst memory interface files
`ifndef PBSI_MAP_VH
`define PBSI_MAP_VH

// ==========================================================
// Geometry
// Word address width presented on the address pins
`define PBSI_ADDR_W 21
// Byte lanes per word, data bits per lane (plus one parity bit each)
`define PBSI_LANES 4
`define PBSI_LANE_DQ_W 8
// Index width of the flip-flop storage actually built
`define PBSI_MEM_AW 8

// ==========================================================
// Burst counter
// Two low address bits take part in a burst of four words
`define PBSI_BURST_W 2
`define PBSI_BURST_STEP 2'h1
`define PBSI_BURST_ZERO 2'h0
// Order select values
`define PBSI_ORDER_LINEAR 1'b0
`define PBSI_ORDER_INTERLEAVED 1'b1

// ==========================================================
// Sleep timing, in clock cycles to enter or to leave sleep
`define PBSI_SLEEP_CYC 2'h2
`define PBSI_SLP_CNT_W 2

// ==========================================================
// Reset values of the command stage (a deselect)
`define PBSI_RST_LOAD 1'b1
`define PBSI_RST_SELECT 1'b0
`define PBSI_RST_WRITE_N 1'b1

`endif

// >>> design/pbsi_burst_seq.v
// Burst address sequencer for the two low address bits
`timescale 1ns/1ps

module pbsi_burst_seq #(
  parameter BW = 2
) (
  input wire [BW-1:0] i_start,
  input wire [BW-1:0] i_step,
  input wire i_interleave,
  output wire [BW-1:0] o_addr
);

  // ==========================================================
  // Sequence
  wire [BW:0] sum_w;

  // Extra bit keeps the carry visible; dropping it is the wrap
  assign sum_w = {1'b0, i_start} + {1'b0, i_step};
  // Interleaved order is start xor step, linear is start plus step
  assign o_addr = i_interleave ? (i_start ^ i_step) : sum_w[BW-1:0];

endmodule // pbsi_burst_seq

// >>> design/pbsi_mem.v
// Byte-lane writable word storage built from flip-flops
`timescale 1ns/1ps

module pbsi_mem #(
  parameter AW = 8,
  parameter LANES = 4,
  parameter LW = 9
) (
  input wire i_clk_sys,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [LANES-1:0] i_wlane,
  input wire [LANES*LW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output wire [LANES*LW-1:0] o_rdata
);

  localparam DEPTH = 1 << AW;
  localparam DW = LANES * LW;

  // ==========================================================
  // Storage
  reg [DW-1:0] mem_r [0:DEPTH-1];
  wire [DW-1:0] bit_sel_w;

  // Widen each lane select across its data and parity bits
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      assign bit_sel_w[g*LW +: LW] = {LW{i_wlane[g]}};
    end
  endgenerate

  // Data array has no reset; only selected lanes change
  always @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_r[i_waddr] <= (mem_r[i_waddr] & ~bit_sel_w) | (i_wdata & bit_sel_w);
    end
  end

  // Read is combinational; the caller registers it
  assign o_rdata = mem_r[i_raddr];

endmodule // pbsi_mem

// >>> design/pbsi_top.v
// Pipelined burst memory device: command pipeline, burst, byte writes, sleep
//
// Summary of operation
// - Inputs other than output gate and reset, and data outputs, pass rising-edge registers
// - Clock qualifier high: edge ignored, state held
// - Load with all selects active starts access
// - Read data appears after the following edge
// - Outputs drive only while output gate low
// - New command accepted every cycle, any mix
// - Load while deselected tri-states after next edge
// - Burst counter gives up to four words
// - Order input: low linear, high interleaved
// - Counter wraps in two low address bits
// - Advance ignores selects and write strobe
// - Burst keeps direction latched at its start
// - Write start registers address and write controls
// - Edge after write command tri-states data lines
// - Write data captured next edge, write completes
// - Only selected byte lanes are written
// - Sleep input high: quiet state, data kept
// - First cycle out of deselect stays tri-stated
// - Powers up deselected with lines tri-stated
// - Two cycles to enter or leave sleep after the two-flop synchroniser, four edges from the pin
`timescale 1ns/1ps
`include "pbsi_map.vh"

module pbsi_top #(
  parameter ADDR_W = `PBSI_ADDR_W,
  parameter LANES = `PBSI_LANES,
  parameter LANE_W = `PBSI_LANE_DQ_W,
  parameter MEM_AW = `PBSI_MEM_AW
) (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire [ADDR_W-1:0] i_addr,
  input wire i_clock_qualifier_n,
  input wire i_chip_select_1_n,
  input wire i_chip_select_2,
  input wire i_chip_select_3_n,
  input wire i_advance_or_load,
  input wire i_write_n,
  input wire [LANES-1:0] i_byte_lane_select_n,
  input wire i_out_drive_n,
  input wire i_sleep_request,
  input wire i_burst_order,
  input wire [LANES*LANE_W-1:0] i_dq,
  output wire [LANES*LANE_W-1:0] o_dq,
  output wire o_dq_oe,
  input wire [LANES-1:0] i_parity_lines,
  output wire [LANES-1:0] o_parity_lines,
  output wire o_parity_lines_oe,
  output wire o_sleeping
);

  // ==========================================================
  // Derived widths
  localparam LW = LANE_W + 1;
  localparam DW = LANES * LW;
  localparam BW = `PBSI_BURST_W;

  // ==========================================================
  // Helpers
  // Overlay the selected lanes of a newer word onto an older one
  function [DW-1:0] lane_merge;
    input [DW-1:0] old_w;
    input [DW-1:0] new_w;
    input [LANES-1:0] sel;
    integer k;
    begin
      lane_merge = old_w;
      for (k = 0; k < LANES; k = k + 1) begin
        if (sel[k]) begin
          lane_merge[k*LW +: LW] = new_w[k*LW +: LW];
        end
      end
    end
  endfunction

  // ==========================================================
  // Declarations
  // Asynchronous pins: sleep request and order strap
  reg slp_meta_r;
  reg slp_sync_r;
  reg ord_meta_r;
  reg ord_sync_r;
  reg sleep_act_r;
  reg [`PBSI_SLP_CNT_W-1:0] slp_cnt_r;

  // Command stage, one set of registered pins
  reg load_r;
  reg sel_r;
  reg write_n_r;
  reg [LANES-1:0] lane_n_r;
  reg [ADDR_W-1:0] addr_r;

  // Burst state
  reg active_r;
  reg dir_wr_r;
  reg [ADDR_W-1:0] base_r;
  reg [BW-1:0] step_r;

  // Read output stage
  reg drive_r;
  reg [DW-1:0] dout_r;

  // Write stages: data pending, then data captured
  reg wp1_vld_r;
  reg [MEM_AW-1:0] wp1_addr_r;
  reg [LANES-1:0] wp1_lane_r;
  reg wp2_vld_r;
  reg [MEM_AW-1:0] wp2_addr_r;
  reg [LANES-1:0] wp2_lane_r;
  reg [DW-1:0] din_r;

  // Decode results
  reg active_nxt;
  reg dir_wr_nxt;
  reg [ADDR_W-1:0] base_nxt;
  reg [BW-1:0] step_nxt;
  reg [ADDR_W-1:0] cur_addr_nxt;
  reg is_rd_nxt;
  reg is_wr_nxt;
  reg [DW-1:0] rd_word_nxt;

  wire advance_w;
  wire [BW-1:0] step_inc_w;
  wire [BW-1:0] burst_lo_w;
  wire [DW-1:0] pin_word_w;
  wire [DW-1:0] mem_rdata_w;
  wire drive_en_w;

  // ==========================================================
  // Edge qualification
  // A qualified edge advances every stage; sleep holds them cleared
  assign advance_w = ~i_clock_qualifier_n & ~sleep_act_r;

  // ==========================================================
  // Pin word packing
  // Lane k carries data byte k with parity bit k on top
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_pack
      assign pin_word_w[g*LW +: LW] = {i_parity_lines[g], i_dq[g*LANE_W +: LANE_W]};
      assign o_dq[g*LANE_W +: LANE_W] = dout_r[g*LW +: LANE_W];
      assign o_parity_lines[g] = dout_r[g*LW + LANE_W];
    end
  endgenerate

  // ==========================================================
  // Asynchronous inputs
  // Sleep request and order strap pass two flip-flops first
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slp_meta_r <= 1'b0;
      slp_sync_r <= 1'b0;
      ord_meta_r <= `PBSI_ORDER_INTERLEAVED;
      ord_sync_r <= `PBSI_ORDER_INTERLEAVED;
    end else begin
      slp_meta_r <= i_sleep_request;
      slp_sync_r <= slp_meta_r;
      ord_meta_r <= i_burst_order;
      ord_sync_r <= ord_meta_r;
    end
  end

  // ==========================================================
  // Sleep entry and exit
  // The request must hold for the full count before the state
  // flips, so a short glitch never drops pending traffic
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sleep_act_r <= 1'b0;
      slp_cnt_r <= {`PBSI_SLP_CNT_W{1'b0}};
    end else if (slp_sync_r != sleep_act_r) begin
      if (slp_cnt_r == `PBSI_SLEEP_CYC - 2'h1) begin
        sleep_act_r <= slp_sync_r;
        slp_cnt_r <= {`PBSI_SLP_CNT_W{1'b0}};
      end else begin
        slp_cnt_r <= slp_cnt_r + 2'h1;
      end
    end else begin
      slp_cnt_r <= {`PBSI_SLP_CNT_W{1'b0}};
    end
  end

  // ==========================================================
  // Command stage
  // Every qualified edge samples the control pins; reset and sleep
  // leave a deselect here, so the device wakes deselected
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_r <= `PBSI_RST_LOAD;
      sel_r <= `PBSI_RST_SELECT;
      write_n_r <= `PBSI_RST_WRITE_N;
      lane_n_r <= {LANES{1'b1}};
      addr_r <= {ADDR_W{1'b0}};
    end else if (sleep_act_r) begin
      load_r <= `PBSI_RST_LOAD;
      sel_r <= `PBSI_RST_SELECT;
      write_n_r <= `PBSI_RST_WRITE_N;
      lane_n_r <= {LANES{1'b1}};
    end else if (advance_w) begin
      load_r <= ~i_advance_or_load;
      sel_r <= ~i_chip_select_1_n & i_chip_select_2 & ~i_chip_select_3_n;
      write_n_r <= i_write_n;
      lane_n_r <= i_byte_lane_select_n;
      addr_r <= i_addr;
    end
  end

  // ==========================================================
  // Burst address
  assign step_inc_w = step_r + `PBSI_BURST_STEP;

  pbsi_burst_seq #(
    .BW(BW)
  ) u_burst (
    .i_start(base_r[BW-1:0]),
    .i_step(step_inc_w),
    .i_interleave(ord_sync_r),
    .o_addr(burst_lo_w)
  );

  // ==========================================================
  // Command decode
  // A load looks at the selects and the write strobe; an advance
  // looks at neither and reuses the direction of the burst
  always @* begin
    active_nxt = active_r;
    dir_wr_nxt = dir_wr_r;
    base_nxt = base_r;
    step_nxt = step_r;
    cur_addr_nxt = base_r;
    is_rd_nxt = 1'b0;
    is_wr_nxt = 1'b0;
    if (load_r && sel_r) begin
      active_nxt = 1'b1;
      dir_wr_nxt = ~write_n_r;
      base_nxt = addr_r;
      step_nxt = `PBSI_BURST_ZERO;
      cur_addr_nxt = addr_r;
      is_rd_nxt = write_n_r;
      is_wr_nxt = ~write_n_r;
    end else if (load_r) begin
      active_nxt = 1'b0;
    end else if (active_r) begin
      step_nxt = step_inc_w;
      cur_addr_nxt = {base_r[ADDR_W-1:BW], burst_lo_w};
      is_rd_nxt = ~dir_wr_r;
      is_wr_nxt = dir_wr_r;
    end
  end

  // ==========================================================
  // Read data with forwarding
  // A write still in flight to the same word must be seen by a
  // read issued straight after it; the newer write lays on top
  always @* begin
    rd_word_nxt = mem_rdata_w;
    if (wp2_vld_r && (wp2_addr_r == cur_addr_nxt[MEM_AW-1:0])) begin
      rd_word_nxt = lane_merge(rd_word_nxt, din_r, wp2_lane_r);
    end
    if (wp1_vld_r && (wp1_addr_r == cur_addr_nxt[MEM_AW-1:0])) begin
      rd_word_nxt = lane_merge(rd_word_nxt, pin_word_w, wp1_lane_r);
    end
  end

  // ==========================================================
  // Burst and output stage
  // Drive is held only for a read data cycle: writes, deselects
  // and the first cycle after a deselect all leave it low
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_r <= 1'b0;
      dir_wr_r <= 1'b0;
      base_r <= {ADDR_W{1'b0}};
      step_r <= `PBSI_BURST_ZERO;
      drive_r <= 1'b0;
      dout_r <= {DW{1'b0}};
    end else if (sleep_act_r) begin
      active_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (advance_w) begin
      active_r <= active_nxt;
      dir_wr_r <= dir_wr_nxt;
      base_r <= base_nxt;
      step_r <= step_nxt;
      drive_r <= is_rd_nxt;
      if (is_rd_nxt) begin
        dout_r <= rd_word_nxt;
      end
    end
  end

  // ==========================================================
  // Write pipeline
  // Stage one waits for data on the bus; stage two holds the
  // captured data and commits it on the next qualified edge
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp1_vld_r <= 1'b0;
      wp1_addr_r <= {MEM_AW{1'b0}};
      wp1_lane_r <= {LANES{1'b0}};
      wp2_vld_r <= 1'b0;
      wp2_addr_r <= {MEM_AW{1'b0}};
      wp2_lane_r <= {LANES{1'b0}};
      din_r <= {DW{1'b0}};
    end else if (sleep_act_r) begin
      wp1_vld_r <= 1'b0;
      wp2_vld_r <= 1'b0;
    end else if (advance_w) begin
      wp1_vld_r <= is_wr_nxt;
      wp1_addr_r <= cur_addr_nxt[MEM_AW-1:0];
      wp1_lane_r <= ~lane_n_r;
      wp2_vld_r <= wp1_vld_r;
      wp2_addr_r <= wp1_addr_r;
      wp2_lane_r <= wp1_lane_r;
      if (wp1_vld_r) begin
        din_r <= pin_word_w;
      end
    end
  end

  // ==========================================================
  // Storage
  // Only a qualified edge commits, so a stall never writes twice
  pbsi_mem #(
    .AW(MEM_AW),
    .LANES(LANES),
    .LW(LW)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_we(wp2_vld_r & advance_w),
    .i_waddr(wp2_addr_r),
    .i_wlane(wp2_lane_r),
    .i_wdata(din_r),
    .i_raddr(cur_addr_nxt[MEM_AW-1:0]),
    .o_rdata(mem_rdata_w)
  );

  // ==========================================================
  // Output drivers
  // The output gate acts without the clock; it can only cut the
  // drive, never open it outside a read data cycle
  assign drive_en_w = drive_r & ~i_out_drive_n & ~sleep_act_r;
  assign o_dq_oe = drive_en_w;
  assign o_parity_lines_oe = drive_en_w;
  assign o_sleeping = sleep_act_r;

endmodule // pbsi_top

// >>> sim/pbsi_top_asserts.sv
// Port-level assertions for the pipelined burst memory device
`timescale 1ns/1ps
module pbsi_top_asserts #(
  parameter LANES = 4,
  parameter LANE_W = 8
) (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire i_clock_qualifier_n,
  input wire i_chip_select_1_n,
  input wire i_chip_select_2,
  input wire i_chip_select_3_n,
  input wire i_advance_or_load,
  input wire i_write_n,
  input wire i_out_drive_n,
  input wire i_sleep_request,
  input wire [LANES*LANE_W-1:0] o_dq,
  input wire o_dq_oe,
  input wire o_parity_lines_oe,
  input wire o_sleeping
);
  // ====
  // Qualified edge, full select and load decode
  wire go_w = !i_clock_qualifier_n && !o_sleeping;
  wire sel_w = !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
  wire load_w = go_w && !i_advance_or_load;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // ====
  // Drive control
  AST_PWRUP_TRI: assert property ($rose(i_arst_n) |-> !o_dq_oe)
    else $error("lines driven after reset");
  AST_GATE_MASK: assert property (i_out_drive_n |-> !o_dq_oe && !o_parity_lines_oe)
    else $error("driven with gate high");
  AST_READ_DRIVE: assert property (load_w && sel_w && i_write_n && !i_sleep_request ##1
    go_w && !i_sleep_request |=> o_dq_oe || i_out_drive_n) else $error("read not driven");
  AST_WRITE_TRI: assert property (load_w && sel_w && !i_write_n ##1 go_w |=> !o_dq_oe)
    else $error("driven in write data phase");
  AST_DESEL_TRI: assert property (load_w && !sel_w ##1 go_w |=> !o_dq_oe)
    else $error("driven after deselect");
  AST_ADV_DESEL: assert property (load_w && !sel_w ##1 go_w && i_advance_or_load ##1 go_w
    |=> !o_dq_oe) else $error("advance left deselect");
  // Stall holds data and drive state, sleep aside
  AST_STALL_HOLD: assert property (i_clock_qualifier_n && !o_sleeping
    && !i_sleep_request |=> $stable(o_dq) && ($stable(i_out_drive_n) -> $stable(o_dq_oe)))
    else $error("stall changed outputs");
  // ====
  // Sleep
  AST_SLEEP_IN: assert property (i_sleep_request[*8] |-> o_sleeping)
    else $error("sleep not entered");
  AST_SLEEP_OUT: assert property ((!i_sleep_request)[*8] |-> !o_sleeping)
    else $error("sleep not left");
  AST_SLEEP_MIN: assert property ($rose(i_sleep_request) && !o_sleeping |=> !o_sleeping)
    else $error("sleep entered too soon");
  AST_SLEEP_QUIET: assert property (o_sleeping |-> !o_dq_oe)
    else $error("driven while asleep");
endmodule // pbsi_top_asserts

// >>> sim/pbsi_ctl_model.sv
// Memory controller model: command pins and write data owed two edges later
`timescale 1ns/1ps
module pbsi_ctl_model #(
  parameter AW = 21,
  parameter DW = 36
) (
  output reg [AW-1:0] o_addr,
  output reg o_cq_n,
  output reg [2:0] o_sel,
  output reg o_adv,
  output reg o_wr_n,
  output reg [3:0] o_lane_n,
  output reg [DW-1:0] o_wdata
);
  // Top bit marks a write word still owed to the device
  reg [DW:0] p1 = {(DW+1){1'b0}};
  reg [DW:0] p2 = {(DW+1){1'b0}};
  // ====
  // Idle at time zero: edges ignored, device deselected
  initial begin
    o_addr = {AW{1'b0}};
    o_cq_n = 1'b1;
    o_sel = 3'h0;
    o_adv = 1'b0;
    o_wr_n = 1'b1;
    o_lane_n = 4'hF;
    o_wdata = {DW{1'b0}};
  end
  // Called just after a falling edge; a stall keeps owed data waiting
  task drive(input q_n, input a_n, input [2:0] s, input w_n, input [AW-1:0] a,
             input [3:0] ln, input w, input [DW-1:0] d);
    begin
      o_cq_n = q_n;
      o_adv = a_n;
      o_sel = s;
      o_wr_n = w_n;
      o_addr = a;
      o_lane_n = ln;
      // Unused lines toggle so stale data never looks valid
      o_wdata = p2[DW] ? p2[DW-1:0] : ~o_wdata;
      if (!q_n) begin
        p2 = p1;
        p1 = {w, d};
      end
    end
  endtask
endmodule // pbsi_ctl_model

// >>> sim/tb_top.sv
// Self-checking bench for the pipelined burst memory device
`timescale 1ns/1ps
module tb_top;
  reg i_clk_sys = 1'b0;
  reg i_arst_n = 1'b0;
  reg i_out_drive_n = 1'b0;
  reg i_sleep_request = 1'b0;
  reg i_burst_order = 1'b0;
  wire [20:0] addr;
  wire [2:0] sel;
  wire cq_n, adv, wr_n, o_dq_oe, o_par_oe, o_sleeping;
  wire [3:0] lane_n;
  wire [3:0] o_par;
  wire [35:0] wdata;
  wire [31:0] o_dq;
  integer errors = 0;
  integer n_checks = 0;
  integer i;
  reg [31:0] rnd = 32'h6736698C;
  reg [35:0] mem_m [0:255];
  // Expectation pipe: check flag, read flag, word
  reg [37:0] e1 = 38'h0;
  reg [37:0] e2 = 38'h0;
  reg act = 1'b0;
  reg wr = 1'b0;
  reg [20:0] st = 21'h0;
  reg [1:0] n = 2'h0;
  always #25 i_clk_sys = ~i_clk_sys;
  pbsi_ctl_model u_pbsi_ctl_model (.o_addr(addr), .o_cq_n(cq_n), .o_sel(sel), .o_adv(adv),
    .o_wr_n(wr_n), .o_lane_n(lane_n), .o_wdata(wdata));
  pbsi_top u_pbsi_top (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_addr(addr),
    .i_clock_qualifier_n(cq_n), .i_chip_select_1_n(sel[2]), .i_chip_select_2(sel[1]),
    .i_chip_select_3_n(sel[0]), .i_advance_or_load(adv), .i_write_n(wr_n),
    .i_byte_lane_select_n(lane_n), .i_out_drive_n(i_out_drive_n),
    .i_sleep_request(i_sleep_request), .i_burst_order(i_burst_order), .i_dq(wdata[31:0]),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_parity_lines(wdata[35:32]), .o_parity_lines(o_par),
    .o_parity_lines_oe(o_par_oe), .o_sleeping(o_sleeping));
  // ====
  // Helpers
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  task cmp_word(input [35:0] g, input [35:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cmp_flag(input g, input e);
    cmp_word({35'h0, g}, {35'h0, e});
  endtask
  // One cycle: check the command two qualified edges back, then model and drive
  task step(input q_n, input a_n, input [2:0] s, input w_n, input [20:0] a,
            input [3:0] ln, input g);
    reg [1:0] lo;
    reg [7:0] ix;
    reg [35:0] d;
    integer j;
    begin
      @(negedge i_clk_sys);
      if (e2[37]) begin
        cmp_flag(o_dq_oe, e2[36] & ~i_out_drive_n);
        cmp_flag(o_par_oe, e2[36] & ~i_out_drive_n);
        if (e2[36] && !i_out_drive_n) begin
          cmp_word({o_par, o_dq}, e2[35:0]);
        end
      end
      rnd = lfsr(rnd);
      d = {rnd[7:4], rnd};
      if (!q_n) begin
        if (!a_n) begin
          act = (s == 3'b010);
          wr = !w_n;
          st = a;
          n = 2'h0;
        end else begin
          n = n + 2'h1;
        end
        lo = i_burst_order ? (st[1:0] ^ n) : (st[1:0] + n);
        ix = {st[7:2], lo};
        e2 = e1;
        e1 = {1'b1, act & !wr, mem_m[ix]};
        for (j = 0; j < 4; j = j + 1)
          if (act && wr && !ln[j]) begin
            mem_m[ix][8*j +: 8] = d[8*j +: 8];
            mem_m[ix][32+j] = d[32+j];
          end
      end
      u_pbsi_ctl_model.drive(q_n, a_n, s, w_n, a, ln, act & wr, d);
      i_out_drive_n = g;
    end
  endtask
  // Random mix of loads, advances, deselects, stalls and gate changes
  task rand_ops;
    for (i = 0; i < 200; i = i + 1) begin
      rnd = lfsr(rnd);
      step(rnd[4:2] == 3'h0, rnd[1:0] == 2'h3, rnd[16] ? rnd[7:5] : 3'b010, rnd[8],
           rnd[31:11], rnd[12:9], rnd[15:13] == 3'h0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ====
  // Main sequence
  initial begin
    repeat (10) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    cmp_flag(o_dq_oe, 1'b0);
    cmp_flag(o_sleeping, 1'b0);
    // Fill all stored words with linear four-word write bursts
    for (i = 0; i < 256; i = i + 1)
      step(0, i % 4 != 0, 3'b010, 0, i, 4'h0, 0);
    $display("test fill done");
    // Partial write read straight back, then an abort
    step(0, 0, 3'b010, 0, 21'h5, 4'hA, 0);
    step(0, 0, 3'b010, 1, 21'h5, 4'hF, 0);
    step(0, 0, 3'b010, 0, 21'h5, 4'hF, 0);
    step(0, 0, 3'b010, 1, 21'h5, 4'h0, 0);
    rand_ops;
    $display("test linear mix done");
    // Strap change and sleep, selects held off around it
    i_burst_order = 1'b1;
    i_sleep_request = 1'b1;
    step(0, 0, 3'h0, 1, 21'h0, 4'hF, 0);
    // One edge after the request the synchroniser has not passed it on yet
    cmp_flag(o_sleeping, 1'b0);
    repeat (7) step(0, 0, 3'h0, 1, 21'h0, 4'hF, 0);
    cmp_flag(o_sleeping, 1'b1);
    i_sleep_request = 1'b0;
    repeat (8) step(0, 0, 3'h0, 1, 21'h0, 4'hF, 0);
    cmp_flag(o_sleeping, 1'b0);
    $display("test sleep done");
    rand_ops;
    $display("test interleaved mix done");
    step(0, 0, 3'h0, 1, 21'h0, 4'hF, 0);
    step(0, 0, 3'h0, 1, 21'h0, 4'hF, 0);
    end_of_test;
  end
  // Watchdog well beyond the few hundred cycles of the sequence
  initial begin
    #200000;
    errors = errors + 1;
    $display("MISMATCH t=%0t watchdog", $time);
    end_of_test;
  end
endmodule // tb_top
bind pbsi_top pbsi_top_asserts #(.LANES(LANES), .LANE_W(LANE_W)) u_pbsi_top_asserts (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clock_qualifier_n(i_clock_qualifier_n),
  .i_chip_select_1_n(i_chip_select_1_n), .i_chip_select_2(i_chip_select_2),
  .i_chip_select_3_n(i_chip_select_3_n), .i_advance_or_load(i_advance_or_load),
  .i_write_n(i_write_n), .i_out_drive_n(i_out_drive_n), .i_sleep_request(i_sleep_request),
  .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_parity_lines_oe(o_parity_lines_oe),
  .o_sleeping(o_sleeping));
